/* File: logic/ata_exec_map.svh */
// Constants of the card command executor: command codes, answer codes,
// identify words and timing. Assumes a 250 MHz core clock.
`ifndef ATA_EXEC_MAP_SVH
`define ATA_EXEC_MAP_SVH

`define CMD_PWR_CHECK_A 8'hE5
`define CMD_PWR_CHECK_B 8'h98
`define CMD_DIAG 8'h90
`define CMD_ERASE 8'hC0
`define CMD_FORMAT 8'h50
`define CMD_IDENTIFY 8'hEC
`define CMD_IDLE_A 8'hE3
`define CMD_IDLE_B 8'h97
`define CMD_IDLE_NOW_A 8'hE1
`define CMD_IDLE_NOW_B 8'h95
`define CMD_INIT_PARAM 8'h91
`define CMD_BUF_READ 8'hE4
`define CMD_READ_MULT 8'hC4
`define CMD_READ_LONG_A 8'h22
`define CMD_READ_LONG_B 8'h23
`define CMD_READ_A 8'h20
`define CMD_READ_B 8'h21
`define CMD_VERIFY_A 8'h40
`define CMD_VERIFY_B 8'h41
`define CMD_RECAL_HI 4'h1
`define CMD_SENSE 8'h03
`define CMD_SEEK_HI 4'h7

`define SENSE_NONE 8'h00
`define SENSE_SELFTEST_OK 8'h01
`define SENSE_BAD_CMD 8'h20
`define SENSE_BAD_ADDR 8'h21
`define SENSE_OVERFLOW 8'h22
`define SENSE_ECC 8'h23
`define SENSE_DIAG_FAIL 8'h24
`define SENSE_NO_SPARE 8'h25

`define DIAG_PASS 8'h01
`define DIAG_FAIL 8'h80
`define ERR_ABORT 8'h04
`define ERR_ECC 8'h40
`define ERR_RANGE 8'h10
`define PWR_ACTIVE 8'hFF
`define PWR_IDLE 8'h80

`define SECTOR_WORDS 9'd256
`define LONG_WORDS 9'd258
`define FMT_FILL 16'h0000

`define ID_GENCFG 16'h848A
`define ID_ECC_BYTES 16'h0004
`define ID_MULT_MAX 16'h0001
`define ID_CAPS 16'h0200
`define ID_PIO_MODE 16'h0200
`define ID_VALID 16'h0003
`define ID_MULT_CUR 16'h0101
`define ID_ADV_PIO 16'h0003
`define ID_PIO_CYCLE 16'h0078
`define ID_ASCII_PAD 16'h2020

`define RECAL_CYCLES 500
`define DIAG_CYCLES 100

`endif

/* File: logic/ata_exec_pkg.sv */
// Types shared by the card command executor and its bench.
// Assumes the task file is held outside and presented as a struct.
package ata_exec_pkg;

    typedef struct packed {
        logic [7:0] features;
        logic [7:0] count;
        logic [7:0] sector;
        logic [15:0] cylinder;
        logic lba_mode;
        logic drive;
        logic [3:0] head;
    } task_file_s;

    typedef struct packed {
        logic busy;
        logic ready;
        logic drq;
        logic err;
    } status_s;

    typedef enum logic [1:0] {
        MEDIA_READ = 2'b00,
        MEDIA_ERASE = 2'b01,
        MEDIA_FORMAT = 2'b10
    } media_op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_MEDIA = 3'b010,
        ST_XFER = 3'b011,
        ST_ABSORB = 3'b100,
        ST_DONE = 3'b101
    } exec_state_e;

endpackage

/* File: logic/ata_card_command_executor.sv */
// Command executor of a flash card behind an ATA-style task file.
// Assumes an outside task file, a media engine that fills the sector
// buffer word by word, and a pad cell that resolves the interrupt pin.
`timescale 1ns/1ns
`default_nettype none
`include "ata_exec_map.svh"

// How it works
// - Power query returns current power state
// - Diagnostic runs self test, code in error
// - Erase conditions each addressed sector
// - Format takes one sector, discards, fills track
// - Identify streams 256-word parameter block
// - Idle: busy, idle, interrupt; count sets autopowerdown
// - Idle immediate keeps power-down timer setting
// - Drive parameters store sectors and heads
// - Buffer read returns buffer, no media
// - Multiple read interrupts once per block
// - Long read moves 516 bytes per sector
// - Read moves 1 to 256 sectors
// - Verify checks ECC, no DRQ, no data
// - Recalibrate waits fixed time then interrupts
// - Identify: ECC bytes, multiple max, LBA
// - Identify: valid words, PIO modes, cycle
// - Identify: capacity MSW first, LBA total
// - Request sense returns last extended error
// - Seek only range-checks the address
// - Interrupt pin floats when disabled or unselected
module ata_card_command_executor #(
    parameter logic [27:0] CAPACITY = 28'd262144,
    parameter logic [15:0] DEF_CYL = 16'd512,
    parameter logic [7:0] DEF_HEADS = 8'd16,
    parameter logic [7:0] DEF_SPT = 8'd32,
    parameter logic [8:0] MULT_BLOCK = 9'd1
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic soft_reset_in,
    input wire ata_exec_pkg::task_file_s task_file_in,
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic status_rd_in,
    input wire logic data_rd_in,
    input wire logic data_wr_in,
    input wire logic host_interrupt_disable_in,
    input wire logic drive_selected_in,
    input wire logic selftest_ok_in,
    input wire logic spares_ok_in,
    input wire logic media_word_valid_in,
    input wire logic [15:0] media_word_in,
    input wire logic media_done_in,
    input wire logic media_ecc_err_in,
    output ata_exec_pkg::status_s status_out,
    output logic [7:0] error_out,
    output logic [7:0] count_out,
    output logic [15:0] data_out,
    output logic media_req_out,
    output ata_exec_pkg::media_op_e media_op_out,
    output logic [27:0] media_lba_out,
    output logic host_interrupt_request_pin_out,
    output logic host_interrupt_request_pin_oe_out
);
    localparam logic [15:0] RECAL_CNT = 16'(`RECAL_CYCLES);
    localparam logic [15:0] DIAG_CNT = 16'(`DIAG_CYCLES);

    ata_exec_pkg::exec_state_e state_r, state_nxt;
    logic [7:0] cmd_r, cmd_nxt, spt_r, spt_nxt, hpc_r, hpc_nxt, apd_time_r, apd_time_nxt;
    logic [7:0] power_r, power_nxt, sense_r, sense_nxt, err_r, err_nxt, count_r, count_nxt;
    logic [8:0] left_r, left_nxt, word_r, word_nxt, blk_r, blk_nxt;
    logic [27:0] lba_r, lba_nxt;
    logic [15:0] wait_r, wait_nxt, dout_r, dout_nxt;
    logic apd_en_r, apd_en_nxt, busy_r, busy_nxt, drq_r, drq_nxt, errflag_r, errflag_nxt;
    logic mreq_r, mreq_nxt, irq_r, irq_nxt, pin_r, pin_nxt, pin_oe_r, pin_oe_nxt;
    ata_exec_pkg::media_op_e mop_r, mop_nxt;
    logic [15:0] buf_r [0:257];
    logic [15:0] buf_nxt [0:257];

    logic is_read, is_long, is_mult, is_verify, is_ident, is_bufrd, ranged;
    logic [27:0] req_lba;
    logic addr_bad, addr_over;
    logic [8:0] req_cnt, xfer_words;
    logic [31:0] chs_lin;
    logic [28:0] req_end;

    function automatic logic [15:0] ident_word(input logic [8:0] idx,
            input logic [7:0] spt, input logic [7:0] hpc);
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            9'd0: w = `ID_GENCFG;
            9'd1: w = DEF_CYL;
            9'd3: w = {8'h00, DEF_HEADS};
            9'd6: w = {8'h00, DEF_SPT};
            9'd7: w = {4'h0, CAPACITY[27:16]};
            9'd8: w = CAPACITY[15:0];
            9'd22: w = `ID_ECC_BYTES;
            9'd47: w = `ID_MULT_MAX;
            9'd49: w = `ID_CAPS;
            9'd51: w = `ID_PIO_MODE;
            9'd53: w = `ID_VALID;
            9'd54: w = DEF_CYL;
            9'd55: w = {8'h00, hpc};
            9'd56: w = {8'h00, spt};
            9'd57: w = CAPACITY[15:0];
            9'd58: w = {4'h0, CAPACITY[27:16]};
            9'd59: w = `ID_MULT_CUR;
            9'd60: w = CAPACITY[15:0];
            9'd61: w = {4'h0, CAPACITY[27:16]};
            9'd64: w = `ID_ADV_PIO;
            9'd67: w = `ID_PIO_CYCLE;
            9'd68: w = `ID_PIO_CYCLE;
            default: begin
                // Serial, revision and model read as ASCII spaces
                if ((idx >= 9'd10 && idx <= 9'd19) || (idx >= 9'd23 && idx <= 9'd46)) begin
                    w = `ID_ASCII_PAD;
                end
            end
        endcase
        return w;
    endfunction

    always_comb begin
        is_long = (cmd_r == `CMD_READ_LONG_A) || (cmd_r == `CMD_READ_LONG_B);
        is_mult = (cmd_r == `CMD_READ_MULT);
        is_verify = (cmd_r == `CMD_VERIFY_A) || (cmd_r == `CMD_VERIFY_B);
        is_ident = (cmd_r == `CMD_IDENTIFY);
        is_bufrd = (cmd_r == `CMD_BUF_READ);
        is_read = is_long || is_mult || (cmd_r == `CMD_READ_A) || (cmd_r == `CMD_READ_B);
        xfer_words = is_long ? `LONG_WORDS : `SECTOR_WORDS;
    end

    always_comb begin
        chs_lin = (32'(task_file_in.cylinder) * 32'(hpc_r) + 32'(task_file_in.head))
            * 32'(spt_r) + 32'(task_file_in.sector) - 32'd1;
        if (task_file_in.lba_mode) begin
            req_lba = {task_file_in.head, task_file_in.cylinder, task_file_in.sector};
            addr_bad = 1'b0;
        end else begin
            req_lba = chs_lin[27:0];
            addr_bad = (task_file_in.sector == 8'h00) || (task_file_in.sector > spt_r)
                || ({4'h0, task_file_in.head} >= hpc_r) || (chs_lin[31:28] != 4'h0);
        end
        req_cnt = (task_file_in.count == 8'h00) ? 9'd256 : {1'b0, task_file_in.count};
        req_end = {1'b0, req_lba} + 29'(req_cnt);
        addr_over = req_end > {1'b0, CAPACITY};
    end

    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        left_nxt = left_r;
        word_nxt = word_r;
        blk_nxt = blk_r;
        lba_nxt = lba_r;
        wait_nxt = wait_r;
        spt_nxt = spt_r;
        hpc_nxt = hpc_r;
        apd_en_nxt = apd_en_r;
        apd_time_nxt = apd_time_r;
        power_nxt = power_r;
        sense_nxt = sense_r;
        err_nxt = err_r;
        count_nxt = count_r;
        busy_nxt = busy_r;
        drq_nxt = drq_r;
        errflag_nxt = errflag_r;
        dout_nxt = dout_r;
        mreq_nxt = mreq_r;
        mop_nxt = mop_r;
        irq_nxt = irq_r;
        buf_nxt = buf_r;
        ranged = 1'b0;
        // A status read clears the request, but a new event wins
        if (status_rd_in) begin
            irq_nxt = 1'b0;
        end
        case (state_r)
            ata_exec_pkg::ST_IDLE: begin
                // Codes arriving while busy are ignored; parameters are taken here
                if (cmd_wr_in) begin
                    cmd_nxt = cmd_code_in;
                    busy_nxt = 1'b1;
                    drq_nxt = 1'b0;
                    errflag_nxt = 1'b0;
                    err_nxt = 8'h00;
                    sense_nxt = `SENSE_NONE;
                    lba_nxt = req_lba;
                    left_nxt = req_cnt;
                    blk_nxt = 9'd0;
                    word_nxt = 9'd0;
                    wait_nxt = 16'd1;
                    state_nxt = ata_exec_pkg::ST_WAIT;
                    power_nxt = `PWR_ACTIVE;
                    case (cmd_code_in)
                        `CMD_PWR_CHECK_A, `CMD_PWR_CHECK_B: count_nxt = power_r;
                        `CMD_DIAG: wait_nxt = DIAG_CNT;
                        `CMD_IDLE_A, `CMD_IDLE_B: begin
                            apd_en_nxt = (task_file_in.count != 8'h00);
                            apd_time_nxt = task_file_in.count;
                            power_nxt = `PWR_IDLE;
                        end
                        `CMD_IDLE_NOW_A, `CMD_IDLE_NOW_B: power_nxt = `PWR_IDLE;
                        `CMD_INIT_PARAM: begin
                            spt_nxt = task_file_in.count;
                            hpc_nxt = 8'(task_file_in.head) + 8'h01;
                        end
                        `CMD_SENSE: err_nxt = sense_r;
                        `CMD_IDENTIFY: begin
                            state_nxt = ata_exec_pkg::ST_XFER;
                            drq_nxt = 1'b1;
                            irq_nxt = 1'b1;
                            dout_nxt = ident_word(9'd0, spt_r, hpc_r);
                        end
                        `CMD_BUF_READ: begin
                            state_nxt = ata_exec_pkg::ST_XFER;
                            drq_nxt = 1'b1;
                            irq_nxt = 1'b1;
                            dout_nxt = buf_r[0];
                        end
                        `CMD_FORMAT: begin
                            ranged = 1'b1;
                            lba_nxt = req_lba - 28'(task_file_in.sector) + 28'd1;
                            left_nxt = {1'b0, spt_r};
                            state_nxt = ata_exec_pkg::ST_ABSORB;
                            drq_nxt = 1'b1;
                        end
                        `CMD_ERASE, `CMD_READ_A, `CMD_READ_B, `CMD_READ_LONG_A,
                        `CMD_READ_LONG_B, `CMD_READ_MULT, `CMD_VERIFY_A,
                        `CMD_VERIFY_B: begin
                            if (cmd_code_in == `CMD_READ_LONG_A || cmd_code_in == `CMD_READ_LONG_B) begin
                                left_nxt = 9'd1;
                            end
                            ranged = 1'b1;
                            state_nxt = ata_exec_pkg::ST_MEDIA;
                            mreq_nxt = 1'b1;
                            mop_nxt = (cmd_code_in == `CMD_ERASE) ? ata_exec_pkg::MEDIA_ERASE
                                : ata_exec_pkg::MEDIA_READ;
                        end
                        default: begin
                            if (cmd_code_in[7:4] == `CMD_RECAL_HI) begin
                                wait_nxt = RECAL_CNT;
                            end else if (cmd_code_in[7:4] == `CMD_SEEK_HI) begin
                                ranged = 1'b1;
                            end else begin
                                errflag_nxt = 1'b1;
                                err_nxt = `ERR_ABORT;
                                sense_nxt = `SENSE_BAD_CMD;
                            end
                        end
                    endcase
                    if (ranged && (addr_bad || addr_over)) begin
                        errflag_nxt = 1'b1;
                        err_nxt = `ERR_RANGE;
                        sense_nxt = addr_bad ? `SENSE_BAD_ADDR : `SENSE_OVERFLOW;
                        state_nxt = ata_exec_pkg::ST_WAIT;
                        drq_nxt = 1'b0;
                        mreq_nxt = 1'b0;
                    end
                end
            end
            ata_exec_pkg::ST_WAIT: begin
                wait_nxt = wait_r - 16'd1;
                if (wait_r == 16'd1) begin
                    if (cmd_r == `CMD_DIAG) begin
                        err_nxt = selftest_ok_in ? `DIAG_PASS : `DIAG_FAIL;
                        sense_nxt = !selftest_ok_in ? `SENSE_DIAG_FAIL
                            : (!spares_ok_in ? `SENSE_NO_SPARE : `SENSE_SELFTEST_OK);
                    end
                    state_nxt = ata_exec_pkg::ST_DONE;
                end
            end
            ata_exec_pkg::ST_MEDIA: begin
                if (media_word_valid_in && word_r < `LONG_WORDS) begin
                    buf_nxt[word_r] = media_word_in;
                    word_nxt = word_r + 9'd1;
                end
                if (media_done_in) begin
                    mreq_nxt = 1'b0;
                    word_nxt = 9'd0;
                    if (media_ecc_err_in && (is_read || is_verify)) begin
                        errflag_nxt = 1'b1;
                        err_nxt = `ERR_ECC;
                        sense_nxt = `SENSE_ECC;
                        state_nxt = ata_exec_pkg::ST_DONE;
                    end else if (is_read) begin
                        state_nxt = ata_exec_pkg::ST_XFER;
                        drq_nxt = 1'b1;
                        dout_nxt = buf_r[0];
                        if (!is_mult || blk_r == 9'd0) begin
                            irq_nxt = 1'b1;
                        end
                    end else if (left_r == 9'd1 || mop_r == ata_exec_pkg::MEDIA_FORMAT) begin
                        state_nxt = ata_exec_pkg::ST_DONE;
                    end else begin
                        left_nxt = left_r - 9'd1;
                        lba_nxt = lba_r + 28'd1;
                        mreq_nxt = 1'b1;
                    end
                end
            end
            ata_exec_pkg::ST_XFER: begin
                if (data_rd_in) begin
                    word_nxt = word_r + 9'd1;
                    dout_nxt = is_ident ? ident_word(word_r + 9'd1, spt_r, hpc_r)
                        : buf_r[word_r + 9'd1];
                    if (word_r + 9'd1 == xfer_words) begin
                        drq_nxt = 1'b0;
                        word_nxt = 9'd0;
                        blk_nxt = (blk_r + 9'd1 == MULT_BLOCK) ? 9'd0 : blk_r + 9'd1;
                        if (!is_read || left_r == 9'd1) begin
                            busy_nxt = 1'b0;
                            state_nxt = ata_exec_pkg::ST_IDLE;
                        end else begin
                            left_nxt = left_r - 9'd1;
                            lba_nxt = lba_r + 28'd1;
                            mreq_nxt = 1'b1;
                            state_nxt = ata_exec_pkg::ST_MEDIA;
                        end
                    end
                end
            end
            ata_exec_pkg::ST_ABSORB: begin
                if (data_wr_in) begin
                    word_nxt = word_r + 9'd1;
                    if (word_r + 9'd1 == `SECTOR_WORDS) begin
                        word_nxt = 9'd0;
                        drq_nxt = 1'b0;
                        mreq_nxt = 1'b1;
                        mop_nxt = ata_exec_pkg::MEDIA_FORMAT;
                        state_nxt = ata_exec_pkg::ST_MEDIA;
                    end
                end
            end
            ata_exec_pkg::ST_DONE: begin
                busy_nxt = 1'b0;
                irq_nxt = 1'b1;
                state_nxt = ata_exec_pkg::ST_IDLE;
            end
            default: state_nxt = ata_exec_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        pin_nxt = !irq_nxt;
        pin_oe_nxt = irq_nxt && !host_interrupt_disable_in && drive_selected_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || soft_reset_in) begin
            state_r <= ata_exec_pkg::ST_IDLE;
            cmd_r <= 8'h00;
            left_r <= 9'd0;
            word_r <= 9'd0;
            blk_r <= 9'd0;
            lba_r <= 28'h0000000;
            wait_r <= 16'h0000;
            spt_r <= DEF_SPT;
            hpc_r <= DEF_HEADS;
            apd_en_r <= 1'b0;
            apd_time_r <= 8'h00;
            power_r <= `PWR_ACTIVE;
            sense_r <= `SENSE_NONE;
            err_r <= 8'h00;
            count_r <= 8'h00;
            busy_r <= 1'b0;
            drq_r <= 1'b0;
            errflag_r <= 1'b0;
            dout_r <= 16'h0000;
            mreq_r <= 1'b0;
            mop_r <= ata_exec_pkg::MEDIA_READ;
            irq_r <= 1'b0;
            pin_r <= 1'b1;
            pin_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            left_r <= left_nxt;
            word_r <= word_nxt;
            blk_r <= blk_nxt;
            lba_r <= lba_nxt;
            wait_r <= wait_nxt;
            spt_r <= spt_nxt;
            hpc_r <= hpc_nxt;
            apd_en_r <= apd_en_nxt;
            apd_time_r <= apd_time_nxt;
            power_r <= power_nxt;
            sense_r <= sense_nxt;
            err_r <= err_nxt;
            count_r <= count_nxt;
            busy_r <= busy_nxt;
            drq_r <= drq_nxt;
            errflag_r <= errflag_nxt;
            dout_r <= dout_nxt;
            mreq_r <= mreq_nxt;
            mop_r <= mop_nxt;
            irq_r <= irq_nxt;
            pin_r <= pin_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        buf_r <= buf_nxt;
    end

    assign status_out = '{busy: busy_r, ready: !busy_r, drq: drq_r, err: errflag_r};
    assign error_out = err_r;
    assign count_out = count_r;
    assign data_out = dout_r;
    assign media_req_out = mreq_r;
    assign media_op_out = mop_r;
    assign media_lba_out = lba_r;
    assign host_interrupt_request_pin_out = pin_r;
    assign host_interrupt_request_pin_oe_out = pin_oe_r;

endmodule
`default_nettype wire

/* File: dv/ata_exec_monitor.sv */
// Checker bound to the card command executor.
// Assumes one clock domain and the executor's port names.
`timescale 1ns/1ns
`default_nettype none
`include "ata_exec_map.svh"
module ata_exec_monitor (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic soft_reset_in,
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic host_interrupt_disable_in,
    input wire logic drive_selected_in,
    input wire ata_exec_pkg::status_s status_out,
    input wire logic [7:0] error_out,
    input wire logic host_interrupt_request_pin_out,
    input wire logic host_interrupt_request_pin_oe_out
);
    logic take, fall, busy_d_r, rst_d_r;
    logic [7:0] code_r;
    logic [9:0] cnt_r;
    assign take = cmd_wr_in && !status_out.busy;
    // Busy drop caused by reset is not a finish
    assign fall = busy_d_r && !status_out.busy && !rst_d_r;
    always_ff @(posedge sys_clk_in) begin
        busy_d_r <= status_out.busy;
        rst_d_r <= rst_in || soft_reset_in;
        code_r <= take ? cmd_code_in : code_r;
        cnt_r <= status_out.busy ? cnt_r + 10'd1 : 10'd0;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in || soft_reset_in);
    a_cmd_sets_busy: assert property (take |=> status_out.busy) else $error("no busy");
    a_idle_now_len: assert property (take && cmd_code_in == `CMD_IDLE_NOW_B
        |=> status_out.busy ##1 status_out.busy ##1 !status_out.busy) else $error("idle len");
    a_idle_irq_out: assert property (fall && code_r == `CMD_IDLE_A
        && !host_interrupt_disable_in && drive_selected_in
        |-> !host_interrupt_request_pin_out && host_interrupt_request_pin_oe_out)
        else $error("idle irq");
    a_recal_len: assert property (fall && code_r[7:4] == `CMD_RECAL_HI
        |-> cnt_r == 10'(`RECAL_CYCLES + 1)) else $error("recal len");
    a_diag_len: assert property (fall && code_r == `CMD_DIAG
        |-> cnt_r == 10'(`DIAG_CYCLES + 1)) else $error("diag len");
    a_bad_code_abort: assert property (fall && code_r == 8'h00
        |-> status_out.err && error_out == `ERR_ABORT) else $error("abort");
    a_verify_no_drq: assert property (code_r[7:1] == 7'h20 |-> !status_out.drq)
        else $error("verify drq");
    a_irq_masked: assert property (host_interrupt_disable_in || !drive_selected_in
        |=> !host_interrupt_request_pin_oe_out) else $error("irq driven");
endmodule
bind ata_card_command_executor ata_exec_monitor mon (.sys_clk_in, .rst_in, .soft_reset_in,
    .cmd_wr_in, .cmd_code_in, .host_interrupt_disable_in, .drive_selected_in, .status_out,
    .error_out, .host_interrupt_request_pin_out, .host_interrupt_request_pin_oe_out);
`default_nettype wire

/* File: dv/media_model.sv */
// Media engine model: 256 words then a done pulse per request.
// Assumes requests held until done, on the executor clock.
`timescale 1ns/1ns
`default_nettype none
module media_model (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic [27:0] lba_in,
    output logic valid_out,
    output logic [15:0] word_out,
    output logic done_out
);
    initial begin
        valid_out = 0;
        done_out = 0;
        word_out = 16'h0000;
        forever begin
            @(posedge clk_in);
            // Idle word toggles so stale data never matches
            word_out <= ~word_out;
            if (req_in) begin
                repeat (lba_in[0] ? 7 : 1) @(posedge clk_in);
                for (int i = 0; i < 256; i++) begin
                    valid_out <= 1;
                    word_out <= lba_in[15:0] ^ 16'(i);
                    @(posedge clk_in);
                end
                valid_out <= 0;
                done_out <= 1;
                @(posedge clk_in) done_out <= 0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Bench of the card command executor with a media model behind it.
// Assumes design files under logic/ compile first.
`timescale 1ns/1ns
`default_nettype none
`include "ata_exec_map.svh"
module tb_top;
    localparam logic [27:0] CAP = 28'd262144;
    logic clk = 0, rst = 1, srst = 0, wr = 0, srd = 0, rd = 0, dis = 0, ok = 1;
    logic req, mv, md, pin, oe;
    logic [7:0] code = 8'h00, err, cnt;
    logic [15:0] dat, mw, b;
    logic [27:0] lba;
    logic [31:0] seed = 32'd18342;
    int n_errors = 0, n_compared = 0, cyc = 0;
    ata_exec_pkg::task_file_s tf = '0, t = '0;
    ata_exec_pkg::status_s st;
    ata_card_command_executor #(.CAPACITY(CAP)) dut (.sys_clk_in(clk), .rst_in(rst),
        .soft_reset_in(srst), .task_file_in(tf), .cmd_wr_in(wr), .cmd_code_in(code),
        .status_rd_in(srd), .data_rd_in(rd), .data_wr_in(1'b0), .host_interrupt_disable_in(dis),
        .drive_selected_in(1'b1), .selftest_ok_in(ok), .spares_ok_in(1'b1),
        .media_word_valid_in(mv), .media_word_in(mw), .media_done_in(md),
        .media_ecc_err_in(1'b0), .status_out(st), .error_out(err), .count_out(cnt),
        .data_out(dat), .media_req_out(req), .media_op_out(), .media_lba_out(lba),
        .host_interrupt_request_pin_out(pin), .host_interrupt_request_pin_oe_out(oe));
    media_model mm (.clk_in(clk), .req_in(req), .lba_in(lba), .valid_out(mv),
        .word_out(mw), .done_out(md));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cyc == 20000) report_and_stop(1);
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    function automatic logic [15:0] idw(input int i);
        case (i)
            7, 61: return 16'(CAP[27:16]);
            8, 60: return CAP[15:0];
            22: return `ID_ECC_BYTES;
            47: return `ID_MULT_MAX;
            49: return `ID_CAPS;
            53: return `ID_VALID;
            64: return `ID_ADV_PIO;
            67, 68: return `ID_PIO_CYCLE;
            default: return 16'h0000;
        endcase
    endfunction
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            n_errors++;
        end
    endtask
    task cmd(input logic [7:0] c);
        @(posedge clk) tf <= t;
        @(posedge clk) code <= c;
        wr <= 1;
        @(posedge clk) wr <= 0;
        @(negedge clk);
    endtask
    task fin();
        for (int w = 0; w < 3000 && st.busy !== 1'b0; w++) @(negedge clk);
        if (st.busy !== 1'b0) n_errors++;
        $display("test %h done", code);
    endtask
    task rblk(input logic k, input logic [15:0] base);
        for (int i = 0; i < 256; i++) begin
            for (int w = 0; w < 3000 && st.drq !== 1'b1; w++) @(negedge clk);
            if (!k || i inside {7, 8, 22, 47, 49, 53, 60, 61, 64, 67, 68} || i > 68)
                chk("data", k ? idw(i) : base ^ 16'(i), dat);
            @(posedge clk) rd <= 1;
            @(posedge clk) rd <= 0;
            @(negedge clk);
        end
    endtask
    task report_and_stop(input int extra);
        n_errors += extra;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        @(posedge clk) srst <= 1;
        @(posedge clk) srst <= 0;
        @(negedge clk) chk("oe", 16'h0000, 16'(oe));
        cmd(`CMD_PWR_CHECK_A);
        fin();
        chk("power", 16'(`PWR_ACTIVE), 16'(cnt));
        t.count = 8'(rnd() | 16'h0001);
        cmd(`CMD_IDLE_A);
        fin();
        chk("irq", 16'h0001, 16'({pin, oe}));
        @(posedge clk) srd <= 1;
        @(posedge clk) srd <= 0;
        @(posedge clk);
        @(negedge clk) chk("oe", 16'h0000, 16'(oe));
        cmd(`CMD_PWR_CHECK_B);
        fin();
        chk("power", 16'(`PWR_IDLE), 16'(cnt));
        @(posedge clk) dis <= 1;
        cmd(`CMD_IDLE_NOW_B);
        fin();
        chk("oe", 16'h0000, 16'(oe));
        b = rnd();
        @(posedge clk) dis <= 0;
        ok <= b[4];
        cmd({`CMD_RECAL_HI, b[3:0]});
        fin();
        cmd(`CMD_DIAG);
        fin();
        chk("diag", 16'(b[4] ? `DIAG_PASS : `DIAG_FAIL), 16'(err));
        cmd(8'h00);
        fin();
        chk("abort", 16'(`ERR_ABORT), 16'(err));
        cmd({`CMD_SEEK_HI, b[7:4]});
        fin();
        chk("seek", 16'(`ERR_RANGE), 16'(err));
        b = b & 16'h03FF;
        t = '{8'h00, 8'h02, b[7:0], 16'(b[9:8]), 1'b1, 1'b0, 4'h0};
        cmd(`CMD_READ_A);
        chk("lba", b, lba[15:0]);
        rblk(0, b);
        rblk(0, b + 16'h0001);
        fin();
        cmd(`CMD_BUF_READ);
        rblk(0, b + 16'h0001);
        fin();
        t.count = 8'h01;
        cmd(`CMD_VERIFY_B);
        fin();
        chk("verify", 16'h0000, 16'(err));
        cmd(`CMD_IDENTIFY);
        rblk(1, 16'h0000);
        fin();
        report_and_stop(0);
    end
endmodule
`default_nettype wire
